// *** verilog/mbo_pkg.sv ***
// constants for the memory barrier ordering block
package mbo_pkg;
    localparam int STYPE_W = 5;
    localparam int STYPE_HI = 10;
    localparam int STYPE_LO = 6;
    localparam int INSN_W = 32;
    localparam logic [4:0] CODE_FULL = 5'h00;
    localparam logic [4:0] CODE_STORE_STORE = 5'h04;
    localparam logic [4:0] CODE_ORDER_ALL = 5'h10;
    localparam logic [4:0] CODE_ACQUIRE = 5'h11;
    localparam logic [4:0] CODE_RELEASE = 5'h12;
    localparam logic [4:0] CODE_LOAD_LOAD = 5'h13;
    localparam int CNT_W = 8;
    typedef enum logic [1:0] {
        MBO_IDLE,
        MBO_DRAIN,
        MBO_GLOBAL
    } mbo_state_e;
endpackage

// *** verilog/mbo_barrier.sv ***
// memory barrier ordering control: decode, drain and hold of younger accesses
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - barrier type is instruction bits 10 to 6.
// - older loads/stores per code must reach ordering point before completion.
// - younger loads/stores per code held until the barrier completes.
// - code zero also waits for older accesses globally performed.
// - acquire orders older loads, holds younger loads and stores.
// - release orders older loads and stores, holds younger stores.
// - codes 1-3 and 5-15 free for implementation types.
// - any undefined nonzero code acts as full barrier.
// - only uncached or coherent shared accesses are ordered.
// - load performed when later store cannot change its value.
// - store performed when a later load returns its value.
// - load globally performed when performed for every storing agent.
// - store globally performed when every loading agent sees it.
// - coherent dma module counts as a cached coherent processor.
// - ordering point lives in the load/store datapath.
// - strongly ordered system may run barrier as no-operation.
// - older group effects visible before any younger effect.
// - cache maintenance and prefetch count as loads and stores.
module mbo_barrier
    import mbo_pkg::*;
#(
    parameter bit STRONGLY_ORDERED = 1'b0
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic ce,
    input wire logic barrier_valid,
    input wire logic [mbo_pkg::INSN_W-1:0] barrier_insn,
    input wire logic issue_valid,
    input wire logic issue_is_load,
    input wire logic issue_is_store,
    input wire logic issue_is_cachemaint,
    input wire logic issue_sync_type,
    input wire logic older_loads_ordered,
    input wire logic older_stores_ordered,
    input wire logic older_global_done,
    output logic barrier_busy,
    output logic barrier_done,
    output logic hold_loads,
    output logic hold_stores,
    output logic issue_stall,
    output logic [mbo_pkg::STYPE_W-1:0] active_type
);
    import mbo_pkg::*;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    logic [STYPE_W-1:0] stype;
    logic [STYPE_W-1:0] eff;
    logic need_old_ld, need_old_st, want_hold_ld, want_hold_st, need_glob;

    always_comb begin
        stype = barrier_insn[STYPE_HI:STYPE_LO];
        unique case (stype)
            CODE_STORE_STORE, CODE_ORDER_ALL, CODE_ACQUIRE, CODE_RELEASE, CODE_LOAD_LOAD: eff = stype;
            default: eff = CODE_FULL;
        endcase
        need_old_ld = 1'b1;
        need_old_st = 1'b1;
        want_hold_ld = 1'b1;
        want_hold_st = 1'b1;
        need_glob = 1'b0;
        unique case (eff)
            CODE_STORE_STORE: begin
                need_old_ld = 1'b0;
                want_hold_ld = 1'b0;
            end
            CODE_ACQUIRE: begin
                need_old_st = 1'b0;
            end
            CODE_RELEASE: begin
                want_hold_ld = 1'b0;
            end
            CODE_LOAD_LOAD: begin
                need_old_st = 1'b0;
                want_hold_st = 1'b0;
            end
            CODE_ORDER_ALL: begin
                need_glob = 1'b0;
            end
            default: begin
                need_glob = 1'b1;
            end
        endcase
    end

    // ----------------------------------------------------------------
    // barrier sequencer
    // ----------------------------------------------------------------
    mbo_state_e state, next_state;
    logic next_busy, next_done, next_hold_ld, next_hold_st;
    logic [STYPE_W-1:0] next_type;
    logic r_old_ld, r_old_st, r_glob, next_old_ld, next_old_st, next_glob;
    logic ordered_ok;

    always_comb begin
        next_state = state;
        next_busy = barrier_busy;
        next_done = 1'b0;
        next_hold_ld = hold_loads;
        next_hold_st = hold_stores;
        next_type = active_type;
        next_old_ld = r_old_ld;
        next_old_st = r_old_st;
        next_glob = r_glob;
        // ordering status comes from the load/store datapath
        ordered_ok = (!r_old_ld || older_loads_ordered) && (!r_old_st || older_stores_ordered);
        unique case (state)
            MBO_IDLE: begin
                if (barrier_valid) begin
                    next_type = eff;
                    if (STRONGLY_ORDERED) begin
                        next_done = 1'b1;
                    end else begin
                        next_state = MBO_DRAIN;
                        next_busy = 1'b1;
                        next_hold_ld = want_hold_ld;
                        next_hold_st = want_hold_st;
                        next_old_ld = need_old_ld;
                        next_old_st = need_old_st;
                        next_glob = need_glob;
                    end
                end
            end
            MBO_DRAIN: begin
                // performed status judged by the datapath
                if (ordered_ok) begin
                    if (r_glob) begin
                        next_state = MBO_GLOBAL;
                    end else begin
                        next_state = MBO_IDLE;
                        next_busy = 1'b0;
                        next_done = 1'b1;
                        next_hold_ld = 1'b0;
                        next_hold_st = 1'b0;
                    end
                end
            end
            MBO_GLOBAL: begin
                // coherent dma agents are counted by the hierarchy too
                if (older_global_done) begin
                    next_state = MBO_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                    next_hold_ld = 1'b0;
                    next_hold_st = 1'b0;
                end
            end
            default: next_state = MBO_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= MBO_IDLE;
            barrier_busy <= 1'b0;
            barrier_done <= 1'b0;
            hold_loads <= 1'b0;
            hold_stores <= 1'b0;
            active_type <= CODE_FULL;
            r_old_ld <= 1'b0;
            r_old_st <= 1'b0;
            r_glob <= 1'b0;
        end else if (ce) begin
            state <= next_state;
            barrier_busy <= next_busy;
            barrier_done <= next_done;
            hold_loads <= next_hold_ld;
            hold_stores <= next_hold_st;
            active_type <= next_type;
            r_old_ld <= next_old_ld;
            r_old_st <= next_old_st;
            r_glob <= next_glob;
        end
    end

    // ----------------------------------------------------------------
    // younger issue stall
    // ----------------------------------------------------------------
    logic next_stall, is_ld, is_st;

    always_comb begin
        // cache ops count as both loads and stores
        is_ld = issue_is_load || issue_is_cachemaint;
        is_st = issue_is_store || issue_is_cachemaint;
        // stall held classes while a barrier is open
        // younger group waits for older group
        next_stall = issue_valid && issue_sync_type
            && ((next_hold_ld && is_ld) || (next_hold_st && is_st));
    end

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            issue_stall <= 1'b0;
        end else if (ce) begin
            issue_stall <= next_stall;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_store_store_no_load_hold;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && barrier_insn[10:6] == 5'h04 && !STRONGLY_ORDERED)
            |=> (hold_stores && !hold_loads);
    endproperty
    a_store_store_no_load_hold: assert property (p_store_store_no_load_hold) else $error("store barrier hold wrong");

    property p_acquire_holds_both;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && barrier_insn[10:6] == 5'h11 && !STRONGLY_ORDERED)
            |=> (hold_stores && hold_loads && !r_old_st && r_old_ld);
    endproperty
    a_acquire_holds_both: assert property (p_acquire_holds_both) else $error("acquire decode wrong");

    property p_release_stores_only;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && barrier_insn[10:6] == 5'h12 && !STRONGLY_ORDERED)
            |=> (hold_stores && !hold_loads && r_old_st && r_old_ld);
    endproperty
    a_release_stores_only: assert property (p_release_stores_only) else $error("release decode wrong");

    property p_unknown_is_full;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && barrier_insn[10:6] >= 5'h14)
            |=> (active_type == 5'h00);
    endproperty
    a_unknown_is_full: assert property (p_unknown_is_full) else $error("unknown code not full");

    property p_full_needs_global;
        @(posedge mclk) disable iff (!resetn)
        (state == MBO_GLOBAL && !older_global_done) |=> !barrier_done;
    endproperty
    a_full_needs_global: assert property (p_full_needs_global) else $error("done before global");

    sequence s_drain_done;
        state == MBO_DRAIN && ce && ordered_ok && !r_glob;
    endsequence
    property p_drain_completes;
        @(posedge mclk) disable iff (!resetn)
        s_drain_done |=> (barrier_done && !hold_loads && !hold_stores);
    endproperty
    a_drain_completes: assert property (p_drain_completes) else $error("drain did not complete");

    property p_stall_on_held;
        @(posedge mclk) disable iff (!resetn)
        (ce && hold_loads && next_hold_ld && issue_valid && issue_sync_type && issue_is_cachemaint)
            |=> issue_stall;
    endproperty
    a_stall_on_held: assert property (p_stall_on_held) else $error("held access not stalled");

    property p_unsync_never_stall;
        @(posedge mclk) disable iff (!resetn)
        (ce && !issue_sync_type) |=> !issue_stall;
    endproperty
    a_unsync_never_stall: assert property (p_unsync_never_stall) else $error("unsync access stalled");

    property p_load_load_loads_only;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && barrier_insn[STYPE_HI:STYPE_LO] == CODE_LOAD_LOAD
            && !STRONGLY_ORDERED) |=> (hold_loads && !hold_stores && r_old_ld && !r_old_st);
    endproperty
    a_load_load_loads_only: assert property (p_load_load_loads_only) else $error("load barrier decode wrong");

    // strongly ordered build never opens a barrier
    property p_noop_when_strong;
        @(posedge mclk) disable iff (!resetn)
        (ce && state == MBO_IDLE && barrier_valid && STRONGLY_ORDERED)
            |=> (barrier_done && !barrier_busy && !hold_loads && !hold_stores);
    endproperty
    a_noop_when_strong: assert property (p_noop_when_strong) else $error("strong order barrier not a no-op");

    sequence s_full_ordered;
        state == MBO_DRAIN && ce && ordered_ok && r_glob;
    endsequence
    property p_full_waits_global;
        @(posedge mclk) disable iff (!resetn)
        s_full_ordered |=> (state == MBO_GLOBAL && barrier_busy && !barrier_done);
    endproperty
    a_full_waits_global: assert property (p_full_waits_global) else $error("full barrier skipped global wait");

    // low enable must freeze state and every output, stall included
    property p_ce_freezes;
        @(posedge mclk) disable iff (!resetn)
        !ce |=> ($stable(state) && $stable(barrier_busy) && $stable(barrier_done) && $stable(hold_loads)
            && $stable(hold_stores) && $stable(issue_stall) && $stable(active_type));
    endproperty
    a_ce_freezes: assert property (p_ce_freezes) else $error("state moved with enable low");
endmodule
`default_nettype wire

// *** verification/mbo_dp_model.sv ***
// datapath stand-in reporting ordered and globally performed states
`timescale 1ns/1ns
`default_nettype none
module mbo_dp_model (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic barrier_busy,
    input wire logic [7:0] ld_lat,
    input wire logic [7:0] st_lat,
    input wire logic [7:0] gl_lat,
    output logic older_loads_ordered,
    output logic older_stores_ordered,
    output logic older_global_done
);
    logic [7:0] cnt;
    // ----
    // drain timing
    // ----
    // latencies are in cycles since busy rose; c8 means never within a test
    always_ff @(posedge mclk) begin
        if (!resetn || !barrier_busy) begin
            cnt <= 8'h00;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
    assign older_loads_ordered = barrier_busy && cnt >= ld_lat;
    assign older_stores_ordered = barrier_busy && cnt >= st_lat;
    // one access type per location in this stand-in
    // producer flag store waits for the reported global state
    assign older_global_done = barrier_busy && cnt >= gl_lat;
endmodule
`default_nettype wire

// *** verification/mbo_barrier_bench.sv ***
// self-checking bench for the barrier ordering block
`timescale 1ns/1ns
`default_nettype none
module mbo_barrier_bench;
    import mbo_pkg::*;
    logic mclk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic barrier_valid = 1'b0;
    logic [INSN_W-1:0] barrier_insn = '0;
    logic issue_valid = 1'b0;
    logic issue_is_load = 1'b0;
    logic issue_is_store = 1'b0;
    logic issue_is_cachemaint = 1'b0;
    logic issue_sync_type = 1'b0;
    logic older_loads_ordered, older_stores_ordered, older_global_done;
    logic barrier_busy, barrier_done, hold_loads, hold_stores, issue_stall;
    logic [STYPE_W-1:0] active_type;
    logic so_busy, so_done, so_hold_loads, so_hold_stores, so_stall;
    logic [STYPE_W-1:0] so_type;
    logic [7:0] ld_lat = 8'h02;
    logic [7:0] st_lat = 8'h02;
    logic [7:0] gl_lat = 8'h02;
    // reserved codes sent only to prove the full fallback
    logic [4:0] codes[12] = '{5'h00, 5'h04, 5'h10, 5'h11, 5'h12, 5'h13, 5'h01, 5'h03, 5'h05, 5'h0f, 5'h14, 5'h1f};
    int mismatches = 0;
    int check_count = 0;
    initial begin
        forever #10 mclk = ~mclk;
    end
    mbo_barrier u_mbo_barrier (.mclk, .resetn, .ce, .barrier_valid, .barrier_insn, .issue_valid, .issue_is_load,
        .issue_is_store, .issue_is_cachemaint, .issue_sync_type, .older_loads_ordered, .older_stores_ordered,
        .older_global_done, .barrier_busy, .barrier_done, .hold_loads, .hold_stores, .issue_stall, .active_type);
    mbo_dp_model u_mbo_dp_model (.mclk, .resetn, .barrier_busy, .ld_lat, .st_lat, .gl_lat, .older_loads_ordered,
        .older_stores_ordered, .older_global_done);
    // strongly ordered build shares every input with the main one
    mbo_barrier #(.STRONGLY_ORDERED(1'b1)) u_mbo_barrier_so (.mclk, .resetn, .ce, .barrier_valid, .barrier_insn,
        .issue_valid, .issue_is_load, .issue_is_store, .issue_is_cachemaint, .issue_sync_type, .older_loads_ordered,
        .older_stores_ordered, .older_global_done, .barrier_busy(so_busy), .barrier_done(so_done),
        .hold_loads(so_hold_loads), .hold_stores(so_hold_stores), .issue_stall(so_stall), .active_type(so_type));
    // ----
    // helpers
    // ----
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        check_count++;
        if (seen !== want) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, want, seen);
        end
    endtask
    task automatic stop_test();
        if (mismatches == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // {effective code, hold ld, hold st, need ld, need st, need global}
    function automatic logic [9:0] expect_of(input logic [4:0] c);
        case (c)
            CODE_STORE_STORE: return {c, 5'b01010};
            CODE_ORDER_ALL: return {c, 5'b11110};
            CODE_ACQUIRE: return {c, 5'b11100};
            CODE_RELEASE: return {c, 5'b01110};
            CODE_LOAD_LOAD: return {c, 5'b10100};
            default: return {5'h00, 5'b11111};
        endcase
    endfunction
    // leaves the offer up; caller drops it
    task automatic offer(input logic [4:0] code);
        barrier_insn = 32'hffff_f83f | (32'(code) << 6);
        barrier_valid = 1'b1;
        @(posedge mclk);
        #1;
    endtask
    task automatic wait_done(output int n);
        n = 1;
        while (barrier_done !== 1'b1 && n < 60) begin
            @(posedge mclk);
            #1;
            n++;
        end
        check("done", barrier_done, 1'b1);
        if (barrier_done !== 1'b1) begin
            stop_test();
        end
        @(posedge mclk);
        #1;
        check("released", {barrier_busy, barrier_done, hold_loads, hold_stores}, 0);
    endtask
    // ----
    // scenarios
    // ----
    task automatic run_code(input logic [4:0] code);
        logic [9:0] e;
        int n;
        int need;
        e = expect_of(code);
        // classes the code does not wait for never report, so a wrong wait times out
        ld_lat = e[2] ? 8'h03 : 8'hc8;
        st_lat = e[1] ? 8'h05 : 8'hc8;
        gl_lat = e[0] ? 8'h08 : 8'hc8;
        need = e[0] ? 8 : (e[1] ? 5 : 3);
        {issue_valid, issue_is_load, issue_sync_type} = 3'b111;
        offer(code);
        offer(CODE_STORE_STORE);
        barrier_valid = 1'b0;
        check("busy", barrier_busy, 1'b1);
        check("hold loads", hold_loads, e[4]);
        check("hold stores", hold_stores, e[3]);
        check("stall", issue_stall, e[4]);
        check("type", active_type, e[9:5]);
        wait_done(n);
        check("early", n > need, 1'b1);
    endtask
    task automatic class_stall();
        logic [3:0] cls[4] = '{4'b1001, 4'b0101, 4'b0011, 4'b1000};
        logic want[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
        int n;
        ld_lat = 8'h28;
        st_lat = 8'h28;
        gl_lat = 8'hc8;
        issue_valid = 1'b1;
        offer(CODE_LOAD_LOAD);
        barrier_valid = 1'b0;
        foreach (cls[i]) begin
            {issue_is_load, issue_is_store, issue_is_cachemaint, issue_sync_type} = cls[i];
            repeat (2) @(posedge mclk);
            #1;
            check("class stall", issue_stall, want[i]);
        end
        wait_done(n);
    endtask
    task automatic reset_mid();
        ld_lat = 8'hc8;
        st_lat = 8'hc8;
        gl_lat = 8'hc8;
        offer(CODE_FULL);
        barrier_valid = 1'b0;
        repeat (3) @(posedge mclk);
        #1;
        resetn = 1'b0;
        @(posedge mclk);
        #1;
        resetn = 1'b1;
        check("reset mid", {barrier_busy, hold_loads, hold_stores}, 0);
    endtask
    task automatic ce_freeze();
        int n;
        ld_lat = 8'hc8;
        st_lat = 8'h03;
        gl_lat = 8'hc8;
        offer(CODE_STORE_STORE);
        barrier_valid = 1'b0;
        ce = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        // stores are ordered by now, but a frozen block must not finish
        check("frozen", {barrier_busy, barrier_done, hold_stores}, 3'b101);
        ce = 1'b1;
        wait_done(n);
        check("resume", n, 2);
    endtask
    task automatic strong_order();
        int n;
        ld_lat = 8'h03;
        st_lat = 8'h03;
        gl_lat = 8'h03;
        offer(CODE_FULL);
        barrier_valid = 1'b0;
        check("no-op done", {so_busy, so_done, so_hold_loads, so_hold_stores, so_stall, so_type},
            {5'b01000, CODE_FULL});
        @(posedge mclk);
        #1;
        check("no-op pulse", so_done, 1'b0);
        wait_done(n);
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        #1;
        check("reset", {barrier_busy, barrier_done, hold_loads, hold_stores, issue_stall, active_type}, 0);
        resetn = 1'b1;
        foreach (codes[i]) begin
            run_code(codes[i]);
        end
        ce_freeze();
        strong_order();
        class_stall();
        reset_mid();
        run_code(CODE_RELEASE);
        stop_test();
    end
endmodule
`default_nettype wire
